/* logic/thc_err.sv */
// Two-hand control sequencer with error handling and an AXI4-Lite register slave.
// Operation
// - Any error forces the safety output low while the error lasts.
// - Error is left only on deactivation or when both buttons read released together.
// - Only first button pressed at activation gives error C010.
// - Only second button pressed at activation gives error C020.
// - Both buttons pressed at activation gives error C030.
// - Window expiry with only second button pressed gives error C040.
// - Window expiry with only first button pressed gives error C050.
// - Window expiry as both become pressed gives error C060.
// - Single-button states show 8804 or 8806 and start the window timer.
// - Diagnostic word is zero after reset and while inactive.
// - Deactivation returns to idle from any state with top priority.
`include "thc_defs.svh"
`default_nettype none
module thc_err
   import thc_pkg::*;
#(
   parameter int TICK_CYCLES = `THC_TICK_TIME_US * `THC_MCLK_MHZ,
   parameter int WINDOW_TICKS = `THC_WINDOW_MS * 1000 / `THC_TICK_TIME_US
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic first_pushbutton_in,
   input wire logic second_pushbutton_in,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic two_hand_safe_output,
   output logic ready,
   output logic protective_request,
   output logic error,
   output logic [15:0] diagnostic_word
);
   // Byte-lane merge of a write into a register word.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Output word implied by a state and a latched error code.
   function automatic thc_out_s outs(input thc_state_e s, input logic [15:0] ec);
      thc_out_s o;
      o = '{ready: 1'b1, safe: 1'b0, demand: 1'b1, error: 1'b0, diag: `THC_DIAG_IDLE};
      case (s)
         THC_IDLE: begin
            o = '{ready: 1'b0, safe: 1'b0, demand: 1'b0, error: 1'b0, diag: `THC_DIAG_IDLE};
         end
         THC_INIT: begin
            o.demand = 1'b0;
            o.diag = `THC_DIAG_INIT;
         end
         THC_REL: o.diag = `THC_DIAG_REL;
         THC_B1: o.diag = `THC_DIAG_B1;
         THC_B2: o.diag = `THC_DIAG_B2;
         THC_ACT: begin
            o.safe = 1'b1;
            o.demand = 1'b0;
            o.diag = `THC_DIAG_ACT;
         end
         THC_LOCK: o.diag = `THC_DIAG_LOCK;
         THC_ERR: begin
            o.demand = 1'b0;
            o.error = 1'b1;
            o.diag = ec;
         end
         default: o = '{ready: 1'b0, safe: 1'b0, demand: 1'b0, error: 1'b0, diag: `THC_DIAG_IDLE};
      endcase
      return o;
   endfunction

   logic b1;
   logic b2;
   assign b1 = first_pushbutton_in;
   assign b2 = second_pushbutton_in;

   // Register file and bus state.
   logic act_ff, nxt_act;
   logic [31:0] tdiv_ff, nxt_tdiv;
   logic awr_ff, nxt_awr;
   logic bv_ff, nxt_bv;
   logic [1:0] br_ff, nxt_br;
   logic arr_ff, nxt_arr;
   logic rv_ff, nxt_rv;
   logic [1:0] rr_ff, nxt_rr;
   logic [31:0] rd_ff, nxt_rd;
   thc_out_s out_ff, nxt_out;

   // Write path: address and data are taken together, then one response.
   always_comb begin
      nxt_act = act_ff;
      nxt_tdiv = tdiv_ff;
      nxt_awr = !awr_ff && s_axi_awvalid && s_axi_wvalid && !bv_ff;
      nxt_bv = bv_ff && !s_axi_bready;
      nxt_br = br_ff;
      if (awr_ff) begin
         nxt_bv = 1'b1;
         nxt_br = `THC_RESP_OKAY;
         case (s_axi_awaddr)
            `THC_OFS_CTRL: nxt_act = s_axi_wstrb[`THC_CTRL_ACT_BIT / 8] ? s_axi_wdata[`THC_CTRL_ACT_BIT] : act_ff;
            `THC_OFS_TICK: nxt_tdiv = merge(tdiv_ff, s_axi_wdata, s_axi_wstrb);
            `THC_OFS_STATUS: nxt_br = `THC_RESP_OKAY;
            default: nxt_br = `THC_RESP_SLVERR;
         endcase
      end
   end

   // Read path: one read under way, data held until taken.
   always_comb begin
      nxt_arr = !arr_ff && s_axi_arvalid && !rv_ff;
      nxt_rv = rv_ff && !s_axi_rready;
      nxt_rr = rr_ff;
      nxt_rd = rd_ff;
      if (arr_ff) begin
         nxt_rv = 1'b1;
         nxt_rr = `THC_RESP_OKAY;
         nxt_rd = 32'h0000_0000;
         case (s_axi_araddr)
            `THC_OFS_CTRL: nxt_rd[`THC_CTRL_ACT_BIT] = act_ff;
            `THC_OFS_STATUS: begin
               nxt_rd[15:0] = out_ff.diag;
               nxt_rd[`THC_ST_READY_BIT] = out_ff.ready;
               nxt_rd[`THC_ST_OUT_BIT] = out_ff.safe;
               nxt_rd[`THC_ST_DEMAND_BIT] = out_ff.demand;
               nxt_rd[`THC_ST_ERROR_BIT] = out_ff.error;
            end
            `THC_OFS_TICK: nxt_rd = tdiv_ff;
            default: nxt_rr = `THC_RESP_SLVERR;
         endcase
      end
   end

   // Execution tick generator; the sequencer steps once per tick.
   logic [31:0] tk_ff, nxt_tk;
   logic tick_ff, nxt_tick;
   always_comb begin
      nxt_tick = 1'b0;
      nxt_tk = tk_ff + 32'h0000_0001;
      if (tk_ff + 32'h0000_0001 >= tdiv_ff) begin
         nxt_tk = 32'h0000_0000;
         nxt_tick = 1'b1;
      end
   end

   // Sequencer with simultaneity timer.
   thc_state_e st_ff, nxt_st;
   logic [15:0] ec_ff, nxt_ec;
   logic [31:0] tmr_ff, nxt_tmr;
   logic expired;
   always_comb begin
      nxt_st = st_ff;
      nxt_ec = ec_ff;
      nxt_tmr = tmr_ff;
      expired = tmr_ff + 32'h0000_0001 >= 32'(WINDOW_TICKS);
      if (!act_ff) begin
         nxt_st = THC_IDLE;
      end else if (tick_ff) begin
         if (st_ff == THC_B1 || st_ff == THC_B2) begin
            nxt_tmr = tmr_ff + 32'h0000_0001;
         end
         case (st_ff)
            THC_IDLE: nxt_st = THC_INIT;
            THC_INIT: begin
               nxt_st = THC_ERR;
               if (b1 && b2) begin
                  nxt_ec = `THC_DIAG_C030;
               end else if (b1) begin
                  nxt_ec = `THC_DIAG_C010;
               end else if (b2) begin
                  nxt_ec = `THC_DIAG_C020;
               end else begin
                  nxt_st = THC_REL;
               end
            end
            THC_REL: begin
               nxt_tmr = 32'h0000_0000;
               if (b1 && b2) begin
                  nxt_st = THC_ACT;
               end else if (b1) begin
                  nxt_st = THC_B1;
               end else if (b2) begin
                  nxt_st = THC_B2;
               end
            end
            THC_B1, THC_B2: begin
               if (expired && (b1 || b2)) begin
                  nxt_st = THC_ERR;
                  if (b1 && b2) begin
                     nxt_ec = `THC_DIAG_C060;
                  end else if (b1) begin
                     nxt_ec = `THC_DIAG_C050;
                  end else begin
                     nxt_ec = `THC_DIAG_C040;
                  end
               end else if (!b1 && !b2) begin
                  nxt_st = THC_REL;
               end else if (b1 && b2) begin
                  nxt_st = THC_ACT;
               end
            end
            THC_ACT: begin
               if (!(b1 && b2)) begin
                  nxt_st = THC_LOCK;
               end
            end
            THC_LOCK, THC_ERR: begin
               if (!b1 && !b2) begin
                  nxt_st = THC_REL;
               end
            end
            default: nxt_st = THC_IDLE;
         endcase
      end
      nxt_out = outs(nxt_st, nxt_ec);
   end

   // All registers of the block.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         act_ff <= `THC_CTRL_RST;
         tdiv_ff <= 32'(TICK_CYCLES);
         awr_ff <= 1'b0;
         bv_ff <= 1'b0;
         br_ff <= `THC_RESP_OKAY;
         arr_ff <= 1'b0;
         rv_ff <= 1'b0;
         rr_ff <= `THC_RESP_OKAY;
         rd_ff <= 32'h0000_0000;
         tk_ff <= 32'h0000_0000;
         tick_ff <= 1'b0;
         st_ff <= THC_IDLE;
         ec_ff <= `THC_DIAG_IDLE;
         tmr_ff <= 32'h0000_0000;
         out_ff <= '{ready: 1'b0, safe: 1'b0, demand: 1'b0, error: 1'b0, diag: `THC_DIAG_IDLE};
      end else begin
         act_ff <= nxt_act;
         tdiv_ff <= nxt_tdiv;
         awr_ff <= nxt_awr;
         bv_ff <= nxt_bv;
         br_ff <= nxt_br;
         arr_ff <= nxt_arr;
         rv_ff <= nxt_rv;
         rr_ff <= nxt_rr;
         rd_ff <= nxt_rd;
         tk_ff <= nxt_tk;
         tick_ff <= nxt_tick;
         st_ff <= nxt_st;
         ec_ff <= nxt_ec;
         tmr_ff <= nxt_tmr;
         out_ff <= nxt_out;
      end
   end

   // Ports straight from flip-flops.
   assign s_axi_awready = awr_ff;
   assign s_axi_wready = awr_ff;
   assign s_axi_bvalid = bv_ff;
   assign s_axi_bresp = br_ff;
   assign s_axi_arready = arr_ff;
   assign s_axi_rvalid = rv_ff;
   assign s_axi_rresp = rr_ff;
   assign s_axi_rdata = rd_ff;
   assign ready = out_ff.ready;
   assign two_hand_safe_output = out_ff.safe;
   assign protective_request = out_ff.demand;
   assign error = out_ff.error;
   assign diagnostic_word = out_ff.diag;

   // Checks of the sequencer against its causes.
   chk_err_out_low: assert property (@(posedge mclk) disable iff (sys_rst)
      error |-> !two_hand_safe_output) else $error("Safety output high during error.");
   chk_err_exit_rel: assert property (@(posedge mclk) disable iff (sys_rst)
      (st_ff == THC_ERR) && act_ff && tick_ff && !b1 && !b2 |=> st_ff == THC_REL && diagnostic_word == `THC_DIAG_REL)
      else $error("Error not left for released state.");
   chk_err_hold: assert property (@(posedge mclk) disable iff (sys_rst)
      (st_ff == THC_ERR) && act_ff && (b1 || b2) |=> error) else $error("Error cleared with a button pressed.");
   chk_init_c010: assert property (@(posedge mclk) disable iff (sys_rst)
      st_ff == THC_INIT && act_ff && tick_ff && b1 && !b2
      |=> diagnostic_word == `THC_DIAG_C010 && ready && error && !protective_request && !two_hand_safe_output)
      else $error("Code C010 not reported.");
   chk_init_c020: assert property (@(posedge mclk) disable iff (sys_rst)
      st_ff == THC_INIT && act_ff && tick_ff && !b1 && b2 |=> diagnostic_word == `THC_DIAG_C020 && error)
      else $error("Code C020 not reported.");
   chk_init_c030: assert property (@(posedge mclk) disable iff (sys_rst)
      st_ff == THC_INIT && act_ff && tick_ff && b1 && b2 |=> diagnostic_word == `THC_DIAG_C030 && error)
      else $error("Code C030 not reported.");
   chk_win_c040: assert property (@(posedge mclk) disable iff (sys_rst)
      (st_ff == THC_B1 || st_ff == THC_B2) && act_ff && tick_ff && expired && !b1 && b2
      |=> diagnostic_word == `THC_DIAG_C040 && error) else $error("Code C040 not reported.");
   chk_win_c050: assert property (@(posedge mclk) disable iff (sys_rst)
      (st_ff == THC_B1 || st_ff == THC_B2) && act_ff && tick_ff && expired && b1 && !b2
      |=> diagnostic_word == `THC_DIAG_C050 && error) else $error("Code C050 not reported.");
   chk_win_c060: assert property (@(posedge mclk) disable iff (sys_rst)
      (st_ff == THC_B1 || st_ff == THC_B2) && act_ff && tick_ff && expired && b1 && b2
      |=> diagnostic_word == `THC_DIAG_C060 && error && !two_hand_safe_output) else $error("Code C060 not reported.");
   chk_single_timer: assert property (@(posedge mclk) disable iff (sys_rst)
      $rose(st_ff == THC_B1) |-> tmr_ff == 32'h0 && diagnostic_word == `THC_DIAG_B1)
      else $error("Single-button state without fresh timer.");
   chk_idle_zero: assert property (@(posedge mclk) disable iff (sys_rst)
      !act_ff |=> diagnostic_word == `THC_DIAG_IDLE && !ready && !error) else $error("Idle word not zero.");
   chk_deact_idle: assert property (@(posedge mclk) disable iff (sys_rst)
      $fell(act_ff) |=> st_ff == THC_IDLE && diagnostic_word == `THC_DIAG_IDLE)
      else $error("Deactivation not to idle.");
endmodule
`default_nettype wire

/* logic/thc_defs.svh */
// Register offsets, field positions, reset values, codes and timing counts of the two-hand error block.
`ifndef THC_DEFS_SVH
`define THC_DEFS_SVH
`define THC_OFS_CTRL 8'h00
`define THC_OFS_STATUS 8'h04
`define THC_OFS_TICK 8'h08
`define THC_CTRL_ACT_BIT 0
`define THC_ST_READY_BIT 16
`define THC_ST_OUT_BIT 17
`define THC_ST_DEMAND_BIT 18
`define THC_ST_ERROR_BIT 19
`define THC_CTRL_RST 1'b0
`define THC_RESP_OKAY 2'h0
`define THC_RESP_SLVERR 2'h2
`define THC_MCLK_MHZ 50
`define THC_TICK_TIME_US 1000
`define THC_WINDOW_MS 500
`define THC_DIAG_IDLE 16'h0000
`define THC_DIAG_ACT 16'h8000
`define THC_DIAG_INIT 16'h8001
`define THC_DIAG_REL 16'h8802
`define THC_DIAG_B1 16'h8804
`define THC_DIAG_B2 16'h8806
`define THC_DIAG_LOCK 16'h880E
`define THC_DIAG_C010 16'hC010
`define THC_DIAG_C020 16'hC020
`define THC_DIAG_C030 16'hC030
`define THC_DIAG_C040 16'hC040
`define THC_DIAG_C050 16'hC050
`define THC_DIAG_C060 16'hC060
`endif

/* logic/thc_pkg.sv */
// Types shared by the two-hand error block.
`default_nettype none
package thc_pkg;
   // One-hot states of the two-hand sequence.
   typedef enum logic [7:0] {
      THC_IDLE = 8'h01,
      THC_INIT = 8'h02,
      THC_REL = 8'h04,
      THC_B1 = 8'h08,
      THC_B2 = 8'h10,
      THC_ACT = 8'h20,
      THC_LOCK = 8'h40,
      THC_ERR = 8'h80
   } thc_state_e;
   // Output word of the block.
   typedef struct packed {
      logic ready;
      logic safe;
      logic demand;
      logic error;
      logic [15:0] diag;
   } thc_out_s;
endpackage
`default_nettype wire

/* tb/thc_btn_model.sv */
// Model of the two operator push-buttons that face the two-hand block.
`default_nettype none
module thc_btn_model (
   input wire logic mclk,
   input wire logic [1:0] hold_req,
   output logic first_pushbutton_in,
   output logic second_pushbutton_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // Contacts follow the operator's hands one edge later; a released contact reads low.
   always_ff @(posedge mclk) begin
      first_pushbutton_in <= hold_req[0];
      second_pushbutton_in <= hold_req[1];
   end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the two-hand error block.
`default_nettype none
module tb_top;
   import thc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int tick_n = 4;
   localparam int win_n = 5;
   logic mclk, sys_rst, first_pushbutton_in, second_pushbutton_in;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, hold_req;
   logic two_hand_safe_output, ready, protective_request, error;
   logic [15:0] diagnostic_word;
   logic [15:0] last_diag = 16'h0000;
   thc_out_s exp_q[$];
   int miscompares, num_checks, cyc, dly, seed, n;
   thc_err #(.TICK_CYCLES(tick_n), .WINDOW_TICKS(win_n)) dut (.mclk, .sys_rst, .first_pushbutton_in,
      .second_pushbutton_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .two_hand_safe_output, .ready, .protective_request, .error, .diagnostic_word);
   thc_btn_model partner (.mclk, .hold_req, .first_pushbutton_in, .second_pushbutton_in);
   // Compares one value and counts the outcome.
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         miscompares++;
         $display("mismatch at %0t: saw %h expected %h", $time, s, e);
      end
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Ends a wait that ran out of its bound.
   task automatic give_up();
      miscompares++;
      $display("mismatch at %0t: wait timed out", $time);
      summarize();
   endtask
   // Expected output word for a diagnostic code.
   function automatic thc_out_s exp_of(input logic [15:0] c);
      return {c != 16'h0000, c == 16'h8000, c[15:12] == 4'h8 && c != 16'h8000 && c != 16'h8001,
         c[15:12] == 4'hC, c};
   endfunction
   // Queues the output word expected at a later code change, behind the notes already queued.
   task automatic note(input logic [15:0] c);
      exp_q.push_back(exp_of(c));
   endtask
   // One register write; the response is compared with the expected code.
   task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 50);
      if (n >= 50) give_up();
      s_axi_bready <= 1'b0;
      check(s_axi_bresp, er);
   endtask
   // One register read; data and response are compared.
   task automatic axr(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er);
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 50);
      if (n >= 50) give_up();
      s_axi_rready <= 1'b0;
      check(s_axi_rdata, ev);
      check(s_axi_rresp, er);
   endtask
   // Operator changes the buttons after a short random pause.
   task automatic press(input logic [1:0] h);
      @(posedge mclk);
      repeat ($random(seed) & 3) @(posedge mclk);
      hold_req <= h;
   endtask
   // Waits, bounded, until the block shows a code.
   task automatic wait_diag(input logic [15:0] c);
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (diagnostic_word !== c && n < 200);
      if (n >= 200) give_up();
   endtask
   // Free-running clock.
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // Every code change is matched with the oldest note; window length is timed too.
   always @(posedge mclk) begin
      cyc++;
      if (sys_rst) begin
         cyc = 0;
      end else if (diagnostic_word !== last_diag) begin
         if (diagnostic_word === 16'hC040 || diagnostic_word === 16'hC050) begin
            dly = cyc;
            check(32'(cyc >= (win_n - 1) * tick_n && cyc <= (win_n + 1) * tick_n), 32'h1);
         end
         if (exp_q.size() == 0) begin
            check(32'h0, 32'h1);
         end else begin
            check({ready, two_hand_safe_output, protective_request, error, diagnostic_word}, exp_q.pop_front());
         end
         last_diag = diagnostic_word;
         cyc = 0;
      end
   end
   // Main sequence.
   initial begin
      seed = 32'hA8E5E0CE;
      sys_rst = 1'b1;
      hold_req = 2'h0;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      repeat (10) @(posedge mclk);
      sys_rst <= 1'b0;
      axr(8'h00, 32'h0, 2'h0);
      axr(8'h08, 32'(tick_n), 2'h0);
      axr(8'h04, 32'h0, 2'h0);
      d = ($random(seed) & 32'h000000FF) + 32'h1;
      axw(8'h08, d, 2'h0);
      axr(8'h08, d, 2'h0);
      axw(8'h08, 32'(tick_n), 2'h0);
      axw(8'h0C, 32'h1, 2'h2);
      axr(8'h0C, 32'h0, 2'h2);
      // Buttons already pressed at activation, then partial release.
      for (int k = 1; k <= 3; k++) begin
         press(2'(k));
         repeat (2 * tick_n) @(posedge mclk);
         note(16'h8001);
         note(16'hC000 | 16'(k << 4));
         axw(8'h00, 32'h1, 2'h0);
         wait_diag(16'hC000 | 16'(k << 4));
         axr(8'h04, {12'h009, 16'hC000 | 16'(k << 4)}, 2'h0);
         press(2'h3);
         repeat (4 * tick_n) @(posedge mclk);
         press(2'h1);
         repeat (4 * tick_n) @(posedge mclk);
         if (k == 3) begin
            note(16'h0000);
         end else begin
            note(16'h8802);
            note(16'h0000);
            press(2'h0);
            wait_diag(16'h8802);
         end
         axw(8'h00, 32'h0, 2'h0);
         wait_diag(16'h0000);
         press(2'h0);
      end
      // One button held alone until the window runs out.
      note(16'h8001);
      note(16'h8802);
      axw(8'h00, 32'h1, 2'h0);
      wait_diag(16'h8802);
      for (int k = 1; k <= 2; k++) begin
         note(16'h8802 + 16'(2 * k));
         note(16'hC060 - 16'(k << 4));
         note(16'h8802);
         press(2'(k));
         wait_diag(16'hC060 - 16'(k << 4));
         press(2'h0);
         wait_diag(16'h8802);
      end
      // Second button lands on the very tick that ends the window.
      note(16'h8804);
      note(16'hC060);
      note(16'h8802);
      press(2'h1);
      wait_diag(16'h8804);
      repeat (win_n * tick_n - 3) @(posedge mclk);
      hold_req <= 2'h3;
      wait_diag(16'hC060);
      press(2'h0);
      wait_diag(16'h8802);
      // Both hands inside the window: output on, then one release locks until both are up.
      note(16'h8804);
      note(16'h8000);
      note(16'h880E);
      note(16'h8802);
      press(2'h1);
      wait_diag(16'h8804);
      press(2'h3);
      wait_diag(16'h8000);
      axr(8'h04, {12'h003, 16'h8000}, 2'h0);
      press(2'h2);
      wait_diag(16'h880E);
      press(2'h0);
      wait_diag(16'h8802);
      repeat (2) @(posedge mclk);
      check(32'(exp_q.size()), 32'h0);
      summarize();
   end
endmodule
`default_nettype wire
